// *** tb_top.sv ***
/*
  Self-checking bench: registers, event counters, token and frame chain.
  Assumes the host memory model and a 10 MHz core clock.
*/
`timescale 1ns/1ps
module tb_top
  import tltcd_pkg::*;
;
  logic               clk = 0, rst_b = 0, wr = 0, rd = 0, token = 0, done = 0, rdy = 0, slow = 0;
  logic [7:0]         addr = 8'h00;
  logic [31:0]        wdata = 32'h0, rdata;
  logic [EVT_NUM-1:0] evt = '0;
  logic               req, we, ack, valid, last, start, pass, pig, lock;
  logic [15:0]        maddr;
  logic [7:0]         mwdata, mrdata, tdata, ctl, nnode;
  logic [7:0]         q[$];
  int                 err_total = 0, cmp_count = 0, cyc = 0, starts = 0;
  logic               last_seen = 0, pass_seen = 0, pig_seen = 0, lock_seen = 0, hold = 1;
  always #50 clk = ~clk;
  tltcd_tx_dma i_dut (.i_core_clk(clk), .i_rst_b(rst_b), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_mem_req(req), .o_mem_we(we), .o_mem_lock(lock),
    .o_mem_addr(maddr), .o_mem_wdata(mwdata), .i_mem_ack(ack), .i_mem_rdata(mrdata), .i_token(token),
    .i_holdoff_done(hold), .i_tx_done(done), .i_event(evt), .i_tx_ready(rdy), .o_tx_valid(valid),
    .o_tx_data(tdata), .o_tx_last(last), .o_tx_start(start), .o_frame_control_byte(ctl), .o_pass_token(pass),
    .o_pass_piggyback(pig), .o_next_node(nnode));
  tltcd_host_mem i_host (.i_core_clk(clk), .i_rst_b(rst_b), .i_slow(slow), .i_mem_req(req),
    .i_mem_we(we), .i_mem_addr(maddr), .i_mem_wdata(mwdata), .o_mem_ack(ack), .o_mem_rdata(mrdata));
  // ==========================================================
  // monitor: engine side stalls every fourth cycle
  always @(posedge clk) begin
    cyc++;
    rdy <= (cyc % 4) != 0;
    if (valid && rdy) begin
      q.push_back(tdata);
      if (last) last_seen = 1;
    end
    if (start) starts++;
    if (lock) lock_seen = 1;
    if (pass) begin
      pass_seen = 1;
      pig_seen  = pig;
    end
    if (cyc == 30000) begin
      err_total++;
      stop_test();
    end
  end
  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'hA5;
  endfunction
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk) {addr, rd} <= {a, 1'b1};
    @(posedge clk) rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    logic [31:0] r;
    reg_rd(REG_CTRL, r); chk_reg(r, CTRL_RESET);
    reg_rd(REG_STATUS, r); chk_reg(r & 32'h5, 32'h4);
    reg_rd(REG_FRAME_LIMIT, r); chk_reg(r, 32'h1);
    reg_rd(8'h1C, r); chk_reg(r, 32'h0);
    reg_wr(REG_CB_PTR, 32'h20); reg_rd(REG_CB_PTR, r); chk_reg(r, 32'h20);
    chk_reg({31'h0, req}, 32'h0);
    reg_wr(REG_OWN_ADDR, 32'h33);
    reg_wr(REG_CTRL, 32'h10000); repeat (30) @(posedge clk);
    reg_rd(REG_STATUS, r); chk_reg(r & 32'h5, 32'h1);
  endtask
  task automatic t_events();
    logic [31:0] r;
    for (int n = 0; n < EVT_NUM; n++) begin
      lock_seen = 0;
      @(posedge clk) evt <= 11'h1 << n;
      @(posedge clk) evt <= '0;
      repeat (40) @(posedge clk);
      chk_byte(i_host.mem[16'h25 + n], (n == EVT_UNUSED) ? 8'(8'h10 + n) : (n == 2) ? CNT_MAX : 8'(8'h11 + n));
      chk_reg({31'h0, lock_seen}, {31'h0, n != EVT_UNUSED});
    end
    @(posedge clk) evt <= 11'h4;
    @(posedge clk) evt <= '0;
    repeat (40) @(posedge clk);
    chk_byte(i_host.mem[16'h27], CNT_MAX);
    chk_byte(i_host.mem[16'h24], 8'h00);
    reg_rd(REG_NEXT_NODE, r); chk_reg(r, 32'h34);
  endtask
  task automatic t_new_next();
    logic [31:0] r;
    reg_wr(REG_NEW_NEXT, 32'h77); reg_wr(REG_CTRL, 32'h10400);
    repeat (20) @(posedge clk);
    reg_rd(REG_CTRL, r); chk_reg(r, 32'h10000);
    chk_byte(nnode, 8'h77);
  endtask
  task automatic t_pass_off(input logic h);
    {pass_seen, starts} = 0;
    @(posedge clk) {token, hold} <= {1'b1, h};
    @(posedge clk) {token, hold} <= 2'b01;
    repeat (20) @(posedge clk);
    chk_reg({pass_seen, pig_seen, starts[29:0]}, 32'h80000000);
  endtask
  task automatic frame_turn(input int len_a, input int a0, input int len_b, input int b0, input logic [7:0] f,
                            input logic p);
    int n = 0;
    q.delete();
    {last_seen, pass_seen, starts} = 0;
    @(posedge clk) token <= 1'b1;
    @(posedge clk) token <= 1'b0;
    while (!last_seen && n < 3000) begin @(posedge clk); n++; end
    chk_byte(ctl, f);
    @(posedge clk) done <= 1'b1;
    @(posedge clk) done <= 1'b0;
    while (!pass_seen && n < 3200) begin @(posedge clk); n++; end
    chk_reg({pass_seen, pig_seen, starts[29:0]}, {1'b1, p, 30'h1});
    chk_reg(32'(q.size()), 32'(len_a + len_b));
    for (int i = 0; i < q.size(); i++) chk_byte(q[i], pat(16'(i < len_a ? a0 + i : b0 + i - len_a)));
  endtask
  // ==========================================================
  initial begin
    logic [31:0] r;
    for (int a = 0; a < 65536; a++) i_host.mem[a] = pat(16'(a));
    // host sets counters, links and lengths
    for (int n = 0; n < EVT_NUM; n++) i_host.mem[16'h25 + n] = 8'h10 + n;
    i_host.mem[16'h27] = 8'hFE;
    {i_host.mem[16'h22], i_host.mem[16'h23], i_host.mem[16'h24]} = 24'h010000;
    {i_host.mem[16'h100], i_host.mem[16'h101], i_host.mem[16'h102]} = 24'h020000;
    {i_host.mem[16'h103], i_host.mem[16'h104], i_host.mem[16'h105]} = 24'h150043;
    {i_host.mem[16'h200], i_host.mem[16'h201]} = 16'h0300;
    {i_host.mem[16'h300], i_host.mem[16'h301], i_host.mem[16'h302]} = 24'h000000;
    {i_host.mem[16'h303], i_host.mem[16'h304], i_host.mem[16'h305]} = 24'h2A0009;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_events();
    t_new_next();
    t_pass_off(1'b1);
    reg_wr(REG_CTRL, 32'h100C0);
    t_pass_off(1'b0);
    slow <= 1'b1;
    frame_turn(58, 16'h106, 1, 16'h202, 8'h15, 1'b1);
    slow <= 1'b0;
    frame_turn(3, 16'h306, 0, 0, 8'h2A, 1'b0);
    reg_rd(REG_STATUS, r); chk_reg(r & 32'h1, 32'h0);
    stop_test();
  end
endmodule

// *** tltcd_host_mem.sv ***
/*
  Host shared-memory model for the transmit-chain DMA block.
  Assumes one byte access at a time, held until the one-cycle ack.
*/
`timescale 1ns/1ps
module tltcd_host_mem (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_slow,
  input  wire logic        i_mem_req,
  input  wire logic        i_mem_we,
  input  wire logic [15:0] i_mem_addr,
  input  wire logic [7:0]  i_mem_wdata,
  output logic             o_mem_ack,
  output logic      [7:0]  o_mem_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] rd_byte;
  logic [1:0] wait_cnt;
  // bus shows junk outside the ack cycle
  assign o_mem_rdata = o_mem_ack ? rd_byte : ~rd_byte;
  // ==========================================================
  // every access answered, slow mode waits
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_mem_ack <= 1'b0;
      wait_cnt  <= 2'h0;
      rd_byte   <= 8'h00;
    end else if (i_mem_req && !o_mem_ack && (!i_slow || wait_cnt == 2'h3)) begin
      o_mem_ack <= 1'b1;
      wait_cnt  <= 2'h0;
      rd_byte   <= mem[i_mem_addr];
      if (i_mem_we) begin
        mem[i_mem_addr] <= i_mem_wdata;
      end
    end else begin
      o_mem_ack <= 1'b0;
      if (i_mem_req && !o_mem_ack) begin
        wait_cnt <= wait_cnt + 2'h1;
      end
    end
  end
endmodule

// *** tltcd_pkg.sv ***
/*
  Shared constants for the token LAN transmit-chain DMA block: register map,
  control bit positions, control-block and buffer layout, frame bytes.
  Assumes byte-addressed host memory with 16-bit addresses.
*/
package tltcd_pkg;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] REG_CTRL        = 8'h00;
  localparam logic [7:0] REG_CB_PTR      = 8'h04;
  localparam logic [7:0] REG_OWN_ADDR    = 8'h08;
  localparam logic [7:0] REG_NEXT_NODE   = 8'h0C;
  localparam logic [7:0] REG_STATUS      = 8'h10;
  localparam logic [7:0] REG_FRAME_LIMIT = 8'h14;
  localparam logic [7:0] REG_NEW_NEXT    = 8'h18;
  // ==========================================================
  // control register bit positions
  localparam int CTRL_ISOLATE   = 0;
  localparam int CTRL_TX_EN     = 6;
  localparam int CTRL_DATA_TX   = 7;
  localparam int CTRL_NEW_NEXT  = 10;
  localparam int CTRL_PIGGYBACK = 16;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  // ==========================================================
  // control block and buffer layout
  localparam logic [15:0] CB_TX_CHAIN  = 16'h0002;
  localparam logic [15:0] CB_SIZE_CODE = 16'h0004;
  localparam logic [15:0] CB_EVT_BASE  = 16'h0005;
  localparam int          EVT_NUM      = 11;
  localparam int          EVT_UNUSED   = 9;
  localparam logic [10:0] BUF_UNIT     = 11'h040;
  localparam logic [10:0] POS_LINK_LO  = 11'h001;
  localparam logic [10:0] POS_STAT     = 11'h002;
  localparam logic [10:0] POS_CTL      = 11'h003;
  localparam logic [10:0] POS_LEN_HI   = 11'h004;
  localparam logic [10:0] POS_LEN_LO   = 11'h005;
  localparam logic [15:0] HDR_BYTES    = 16'h0006;
  localparam logic [15:0] LINK_BYTES   = 16'h0002;
  localparam int          END_TURN_BIT = 0;
  localparam int          ACK_REQ_BIT  = 7;
  localparam logic [7:0]  CNT_MAX      = 8'hFF;
endpackage

// *** tltcd_tx_dma.sv ***
/*
  Transmit-chain DMA and memory event counters of a token LAN controller.
  Assumes a byte-wide memory port answering with a one-cycle ack, a network
  engine that takes bytes by valid/ready and reports token, frame done and
  event pulses, all synchronous to i_core_clk.
*/
// Operation
// R1 - each shared bit: one setter, one clearer
// R2 - new-next request: host sets, device clears
// R3 - counters increment, saturate at 255
// R4 - counters at block offsets five to fifteen
// R5 - scan mode: count, next node = own+1
// R6 - count retry that succeeded second time
// R7 - count underrun or oversize transmit aborts
// R8 - count network dead timer expiries
// R9 - count bad supervisory frame receptions
// R10 - count bad data frame receptions
// R11 - count every negative acknowledge sent
// R12 - count invalid frames, counter nine unused
// R13 - count duplicate tokens
// R14 - count data frames with own source
// R15 - token: send pending frame or pass
// R16 - turn ends on five listed conditions
// R17 - piggyback token when allowed, else explicit
// R18 - read next address at frame end, token
// R19 - keep found address, else flag clear
// R20 - fetch link, control, length; walk buffers
// R21 - host writes length including overhead bytes
// R22 - six overhead bytes in fixed order
// R23 - buffer size in 64 byte steps
// R24 - buffer count and data bytes from length
// R25 - interleave pointer accesses without deadlock
// R26 - buffer size is low nibble plus one
// R27 - zero link seen from upper byte
// R28 - counter update is locked read-modify-write
`timescale 1ns/1ps
module tltcd_tx_dma
  import tltcd_pkg::*;
(
  input  wire logic               i_core_clk,
  input  wire logic               i_rst_b,
  input  wire logic [7:0]         i_reg_addr,
  input  wire logic [31:0]        i_reg_wdata,
  input  wire logic               i_reg_wr,
  input  wire logic               i_reg_rd,
  output logic      [31:0]        o_reg_rdata,
  output logic                    o_mem_req,
  output logic                    o_mem_we,
  output logic                    o_mem_lock,
  output logic      [15:0]        o_mem_addr,
  output logic      [7:0]         o_mem_wdata,
  input  wire logic               i_mem_ack,
  input  wire logic [7:0]         i_mem_rdata,
  input  wire logic               i_token,
  input  wire logic               i_holdoff_done,
  input  wire logic               i_tx_done,
  input  wire logic [EVT_NUM-1:0] i_event,
  input  wire logic               i_tx_ready,
  output logic                    o_tx_valid,
  output logic      [7:0]         o_tx_data,
  output logic                    o_tx_last,
  output logic                    o_tx_start,
  output logic      [7:0]         o_frame_control_byte,
  output logic                    o_pass_token,
  output logic                    o_pass_piggyback,
  output logic      [7:0]         o_next_node
);
  typedef enum logic [3:0] {
    ST_ISO, ST_CB_SIZE, ST_IDLE, ST_CHK_HI, ST_CHK_LO, ST_HDR,
    ST_DATA_RD, ST_DATA_TX, ST_WAIT_DONE, ST_EVT_RD, ST_EVT_WR
  } tltcd_state_type;
  typedef enum logic [1:0] {CTX_START, CTX_FRAME, CTX_TOKEN} tltcd_ctx_type;

  tltcd_state_type    state;
  tltcd_ctx_type      ctx;
  logic [31:0]        ctrl;
  logic [15:0]        cb_ptr;
  logic [7:0]         own_addr;
  logic [7:0]         new_next;
  logic [7:0]         frame_limit;
  logic [7:0]         frame_cnt;
  logic [3:0]         buffer_size_code;
  logic               next_valid;
  logic [15:0]        next_frame;
  logic [15:0]        link_loc;
  logic [7:0]         link_hi;
  logic [15:0]        buf_addr;
  logic [15:0]        buf_link;
  logic [10:0]        pos;
  logic               first_buf;
  logic [15:0]        remain;
  logic [7:0]         frame_status_byte;
  logic [7:0]         len_hi;
  logic               turn_end;
  logic [EVT_NUM-1:0] evt_pend;
  logic [3:0]         evt_idx;
  logic [7:0]         evt_val;

  // ==========================================================
  // register port decode
  wire wr_ctrl  = i_reg_wr && (i_reg_addr == REG_CTRL);
  wire wr_cbp   = i_reg_wr && (i_reg_addr == REG_CB_PTR);
  wire wr_own   = i_reg_wr && (i_reg_addr == REG_OWN_ADDR);
  wire wr_limit = i_reg_wr && (i_reg_addr == REG_FRAME_LIMIT);
  wire wr_newn  = i_reg_wr && (i_reg_addr == REG_NEW_NEXT);
  wire [31:0] status_word = {29'h0000_0000, state == ST_ISO, state != ST_IDLE, next_valid};
  wire [31:0] rd_mux = (i_reg_addr == REG_CTRL)        ? ctrl :
                       (i_reg_addr == REG_CB_PTR)      ? {16'h0000, cb_ptr} :
                       (i_reg_addr == REG_OWN_ADDR)    ? {24'h00_0000, own_addr} :
                       (i_reg_addr == REG_NEXT_NODE)   ? {24'h00_0000, o_next_node} :
                       (i_reg_addr == REG_STATUS)      ? status_word :
                       (i_reg_addr == REG_FRAME_LIMIT) ? {24'h00_0000, frame_limit} :
                       (i_reg_addr == REG_NEW_NEXT)    ? {24'h00_0000, new_next} : 32'h0000_0000;

  wire isolate   = ctrl[CTRL_ISOLATE];
  wire tx_en     = ctrl[CTRL_TX_EN];
  wire data_tx   = ctrl[CTRL_DATA_TX];
  wire load_next_node_request = ctrl[CTRL_NEW_NEXT];
  wire piggy_ok  = ctrl[CTRL_PIGGYBACK];
  wire tx_permit = tx_en && data_tx && i_holdoff_done;
  // R2 device takes the new-next request and clears the bit
  wire load_next_take = load_next_node_request && !i_event[0];

  // R26 size is nibble plus one, R23 in 64 byte units
  wire [10:0] buf_bytes = {7'h00, buffer_size_code} * BUF_UNIT + BUF_UNIT;
  wire [15:0] rd_addr = buf_addr + {5'h00, pos};
  wire [15:0] len_word = {len_hi, i_mem_rdata};

  // R16 turn end conditions known at frame completion
  wire turn_limit = (frame_cnt + 8'h01) >= frame_limit;
  wire end_now = isolate || !data_tx || frame_status_byte[END_TURN_BIT] || turn_limit;
  wire ack_req = o_frame_control_byte[ACK_REQ_BIT];

  // R3 event pick, unused slot ignored
  // R6 R7 R8 R9 R10 R11 R12 R13 R14 one pulse per counter
  wire [EVT_NUM-1:0] evt_in = i_event & ~(EVT_NUM'(1) << EVT_UNUSED);
  logic [3:0] evt_pick;
  always_comb begin
    evt_pick = 4'h0;
    for (int k = EVT_NUM - 1; k >= 0; k--) begin
      if (evt_pend[k]) begin
        evt_pick = 4'(k);
      end
    end
  end
  wire evt_any = |evt_pend;
  wire mem_done = o_mem_req && i_mem_ack;

  // ==========================================================
  // register file
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_reg_rdata <= 32'h0000_0000;
      ctrl        <= CTRL_RESET;
      cb_ptr      <= 16'h0000;
      own_addr    <= 8'h00;
      new_next    <= 8'h00;
      frame_limit <= 8'h01;
      o_next_node <= 8'h00;
    end else begin
      o_reg_rdata <= i_reg_rd ? rd_mux : 32'h0000_0000;
      // R1 host only sets the request bit, device only clears it; set wins
      if (wr_ctrl) begin
        ctrl <= {i_reg_wdata[31:CTRL_NEW_NEXT+1], i_reg_wdata[CTRL_NEW_NEXT] | load_next_node_request,
                 i_reg_wdata[CTRL_NEW_NEXT-1:0]};
      end else if (load_next_take) begin
        ctrl[CTRL_NEW_NEXT] <= 1'b0;
      end
      if (wr_cbp && (state == ST_ISO)) begin
        cb_ptr <= i_reg_wdata[15:0];
      end
      if (wr_own) begin
        own_addr <= i_reg_wdata[7:0];
      end
      if (wr_limit) begin
        frame_limit <= i_reg_wdata[7:0];
      end
      if (wr_newn) begin
        new_next <= i_reg_wdata[7:0];
      end
      // R5 scan mode redefines next node as own plus one
      if (i_event[0]) begin
        o_next_node <= own_addr + 8'h01;
      end else if (load_next_take) begin
        o_next_node <= new_next;
      end
    end
  end

  // R3 sticky pending events, a new event wins over service
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      evt_pend <= '0;
    end else if ((state == ST_EVT_WR) && mem_done) begin
      evt_pend <= (evt_pend & ~(EVT_NUM'(1) << evt_idx)) | evt_in;
    end else begin
      evt_pend <= evt_pend | evt_in;
    end
  end

  // ==========================================================
  // memory port
  always_comb begin
    o_mem_req   = 1'b0;
    o_mem_we    = 1'b0;
    o_mem_addr  = rd_addr;
    o_mem_wdata = 8'h00;
    case (state)
      ST_CB_SIZE: begin
        o_mem_req  = 1'b1;
        o_mem_addr = cb_ptr + CB_SIZE_CODE;
      end
      ST_CHK_HI: begin
        o_mem_req  = 1'b1;
        o_mem_addr = link_loc;
      end
      ST_CHK_LO: begin
        o_mem_req  = 1'b1;
        o_mem_addr = link_loc + 16'h0001;
      end
      ST_HDR, ST_DATA_RD: begin
        o_mem_req = (state == ST_HDR) || ((remain != 16'h0000) && (pos != buf_bytes));
      end
      ST_EVT_RD, ST_EVT_WR: begin
        // R4 counters only at block offsets five onward
        o_mem_req   = 1'b1;
        o_mem_we    = (state == ST_EVT_WR);
        o_mem_addr  = cb_ptr + CB_EVT_BASE + {12'h000, evt_idx};
        // R3 saturating increment
        o_mem_wdata = (evt_val == CNT_MAX) ? CNT_MAX : evt_val + 8'h01;
      end
      default: begin
        o_mem_req = 1'b0;
      end
    endcase
  end
  // R28 bus held between counter read and write-back
  assign o_mem_lock = (state == ST_EVT_RD) || (state == ST_EVT_WR);

  // ==========================================================
  // chain walker
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state            <= ST_ISO;
      ctx              <= CTX_START;
      buffer_size_code <= 4'h0;
      next_valid       <= 1'b0;
      next_frame       <= 16'h0000;
      link_loc         <= 16'h0000;
      link_hi          <= 8'h00;
      buf_addr         <= 16'h0000;
      buf_link         <= 16'h0000;
      pos              <= 11'h000;
      first_buf        <= 1'b1;
      remain           <= 16'h0000;
      frame_status_byte <= 8'h00;
      len_hi           <= 8'h00;
      frame_cnt        <= 8'h00;
      turn_end         <= 1'b0;
      evt_idx          <= 4'h0;
      evt_val          <= 8'h00;
      o_tx_valid       <= 1'b0;
      o_tx_data        <= 8'h00;
      o_tx_last        <= 1'b0;
      o_tx_start       <= 1'b0;
      o_frame_control_byte <= 8'h00;
      o_pass_token     <= 1'b0;
      o_pass_piggyback <= 1'b0;
    end else begin
      o_tx_start   <= 1'b0;
      o_pass_token <= 1'b0;
      case (state)
        ST_ISO: begin
          if (!isolate) begin
            state <= ST_CB_SIZE;
          end
        end
        ST_CB_SIZE: begin
          if (mem_done) begin
            buffer_size_code <= i_mem_rdata[3:0];
            link_loc   <= cb_ptr + CB_TX_CHAIN;
            ctx        <= CTX_START;
            state      <= ST_CHK_HI;
          end
        end
        // R25 counters serviced only in idle between turns, not between frames of one turn
        ST_IDLE: begin
          if (isolate) begin
            state <= ST_ISO;
          end else if (i_token) begin
            frame_cnt <= 8'h00;
            // R15 send on permit, else pass token
            if (!tx_permit) begin
              o_pass_token     <= 1'b1;
              o_pass_piggyback <= 1'b0;
            end else if (next_valid) begin
              buf_addr  <= next_frame;
              pos       <= 11'h000;
              first_buf <= 1'b1;
              state     <= ST_HDR;
            end else begin
              // R18 token with permission re-reads the chain
              ctx   <= CTX_TOKEN;
              state <= ST_CHK_HI;
            end
          end else if (evt_any) begin
            evt_idx <= evt_pick;
            state   <= ST_EVT_RD;
          end
        end
        ST_EVT_RD: begin
          if (mem_done) begin
            evt_val <= i_mem_rdata;
            state   <= ST_EVT_WR;
          end
        end
        ST_EVT_WR: begin
          if (mem_done) begin
            state <= ST_IDLE;
          end
        end
        // R27 zero link judged from the upper byte only
        ST_CHK_HI: begin
          if (mem_done) begin
            link_hi <= i_mem_rdata;
            if (i_mem_rdata == 8'h00) begin
              // R19 no frame: flag clear, pointer stays on zero link
              next_valid <= 1'b0;
              if (ctx == CTX_START) begin
                state <= ST_IDLE;
              end else begin
                // R17 empty chain always gives an explicit pass
                o_pass_token     <= 1'b1;
                o_pass_piggyback <= 1'b0;
                state            <= ST_IDLE;
              end
            end else begin
              state <= ST_CHK_LO;
            end
          end
        end
        ST_CHK_LO: begin
          if (mem_done) begin
            // R19 found address is kept for the next token
            next_valid <= 1'b1;
            next_frame <= {link_hi, i_mem_rdata};
            if ((ctx == CTX_START) || ((ctx == CTX_FRAME) && turn_end)) begin
              // R17 piggyback only when no ack was asked
              o_pass_token     <= (ctx == CTX_FRAME);
              o_pass_piggyback <= !ack_req && piggy_ok;
              state            <= ST_IDLE;
            end else begin
              buf_addr  <= {link_hi, i_mem_rdata};
              pos       <= 11'h000;
              first_buf <= 1'b1;
              state     <= ST_HDR;
            end
          end
        end
        // R20 link, status, control and length fetched first
        ST_HDR: begin
          if (mem_done) begin
            pos <= pos + 11'h001;
            case (pos)
              11'h000: buf_link[15:8] <= i_mem_rdata;
              POS_LINK_LO: begin
                buf_link[7:0] <= i_mem_rdata;
                if (!first_buf) begin
                  remain <= remain - LINK_BYTES;
                  state  <= ST_DATA_RD;
                end
              end
              POS_STAT: frame_status_byte <= i_mem_rdata;
              POS_CTL: o_frame_control_byte <= i_mem_rdata;
              POS_LEN_HI: len_hi <= i_mem_rdata;
              POS_LEN_LO: begin
                // R22 length covers status, control, length, addresses, data
                remain     <= len_word - HDR_BYTES;
                next_valid <= 1'b0;
                o_tx_start <= 1'b1;
                state      <= ST_DATA_RD;
              end
              default: state <= ST_DATA_RD;
            endcase
          end
        end
        // R24 bytes run until length count or buffer end
        ST_DATA_RD: begin
          if (remain == 16'h0000) begin
            state <= ST_WAIT_DONE;
          end else if (pos == buf_bytes) begin
            buf_addr  <= buf_link;
            pos       <= 11'h000;
            first_buf <= 1'b0;
            state     <= ST_HDR;
          end else if (mem_done) begin
            o_tx_data  <= i_mem_rdata;
            o_tx_valid <= 1'b1;
            o_tx_last  <= (remain == 16'h0001);
            remain     <= remain - 16'h0001;
            pos        <= pos + 11'h001;
            state      <= ST_DATA_TX;
          end
        end
        ST_DATA_TX: begin
          if (i_tx_ready) begin
            o_tx_valid <= 1'b0;
            o_tx_last  <= 1'b0;
            state      <= ST_DATA_RD;
          end
        end
        ST_WAIT_DONE: begin
          if (i_tx_done) begin
            // R18 next address read at every frame end
            frame_cnt <= frame_cnt + 8'h01;
            turn_end  <= end_now;
            link_loc  <= buf_addr;
            ctx       <= CTX_FRAME;
            state     <= ST_CHK_HI;
          end
        end
        default: state <= ST_ISO;
      endcase
    end
  end

  // ==========================================================
  // checks
  chk_next_load_clear: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R2
    load_next_take && !wr_ctrl |=> !ctrl[CTRL_NEW_NEXT]) else $error("new-next request not cleared");
  chk_counter_sat: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R3
    (state == ST_EVT_RD) && mem_done |=> o_mem_we && (o_mem_wdata == (($past(i_mem_rdata) == CNT_MAX) ?
      CNT_MAX : $past(i_mem_rdata) + 8'h01)))
    else $error("counter write not saturating increment");
  chk_counter_addr: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R4
    o_mem_we |-> (o_mem_addr >= cb_ptr + CB_EVT_BASE) && (evt_idx != 4'(EVT_UNUSED)))
    else $error("counter write outside counter bytes");
  chk_scan_next: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R5
    i_event[0] |=> (o_next_node == $past(own_addr) + 8'h01)) else $error("next node not own plus one");
  chk_no_permit: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R15
    (state == ST_IDLE) && !isolate && i_token && !tx_permit |=> o_pass_token && !o_pass_piggyback)
    else $error("token not passed without permit");
  chk_empty_pass: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R17
    (state == ST_CHK_HI) && (ctx != CTX_START) && mem_done && (i_mem_rdata == 8'h00)
    |=> o_pass_token && !o_pass_piggyback && !next_valid) else $error("empty chain pass wrong");
  chk_frame_end: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R18
    (state == ST_WAIT_DONE) && i_tx_done |=> (state == ST_CHK_HI) ##0 (link_loc == $past(buf_addr)))
    else $error("next address not read at frame end");
  chk_lock_rmw: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R28
    (state == ST_EVT_RD) && mem_done |=> o_mem_lock throughout (o_mem_we [*1]))
    else $error("counter update not locked");
  chk_length_stop: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R24
    o_tx_valid && o_tx_last |-> (remain == 16'h0000)) else $error("last byte with length left");
  cov_send_frame: cover property (@(posedge i_core_clk) disable iff (!i_rst_b)
    o_tx_start ##[1:300] (state == ST_WAIT_DONE));
  cov_piggyback: cover property (@(posedge i_core_clk) disable iff (!i_rst_b)
    o_pass_token && o_pass_piggyback);
  cov_counter_upd: cover property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (state == ST_EVT_WR) && mem_done);
  cov_next_buffer: cover property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (state == ST_HDR) && !first_buf && mem_done);
endmodule
